// ---- logic/diff_out_params.svh ----
// Offsets, field positions, reset values and codes of the output stage.
// Assumes inclusion by bare name from the output stage design files.
`ifndef DIFF_OUT_PARAMS_SVH
`define DIFF_OUT_PARAMS_SVH

// Register indices as printed; byte address is four times the index
`define IDX_STOP1       18'h324ba
`define IDX_STOP0       18'h324c4
`define IDX_DIFF        18'h324ce
`define ADDR_STOP1      {`IDX_STOP1, 2'b00}
`define ADDR_STOP0      {`IDX_STOP0, 2'b00}
`define ADDR_DIFF       {`IDX_DIFF, 2'b00}
`define ADDR_MODE       20'h00000
`define ADDR_MASK       20'h00004
`define ADDR_STATUS     20'h00008

// Field positions
`define MODE_EIGHT_BIT  0
`define STATUS_REPLAY   0
`define STATUS_DIFF     1
`define STATUS_MODERN   2

// Reset values
`define RST_DIFF        1'b0
`define RST_MODE        1'b0
`define RST_MASK        32'h00000000

// AXI responses
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// ---- logic/diff_out_pkg.sv ----
// Types shared by the output stage modules.
// Assumes no other package is needed.
package diff_out_pkg;
	typedef enum logic [1:0] {
		stop_tristate,
		stop_low,
		stop_high
	} stop_state_e;

	typedef logic [15:0] module_word_t;
endpackage : diff_out_pkg

// ---- logic/stage_if.sv ----
// Bundle between the output stage top and one module's pair mapper.
// Assumes both ends run on the same clock; the mapper is combinational.
`timescale 1ns/1ps
interface stage_if;
	logic                        eight_bit;
	logic                        diff;
	logic                        modern;
	logic                        replay;
	diff_out_pkg::stop_state_e   stop;
	diff_out_pkg::module_word_t  samples;
	diff_out_pkg::module_word_t  word;
	logic                        drive;

	modport feeder (
		output eight_bit,
		output diff,
		output modern,
		output replay,
		output stop,
		output samples,
		input  word,
		input  drive
	);

	modport mapper (
		input  eight_bit,
		input  diff,
		input  modern,
		input  replay,
		input  stop,
		input  samples,
		output word,
		output drive
	);
endinterface : stage_if

// ---- logic/pair_mapper.sv ----
// Maps one module's samples or post-replay state onto its 16 output bits.
// Assumes samples already hold the module's slice in the low bits.
`timescale 1ns/1ps
module pair_mapper #(
	parameter int PAIRS = 8
) (
	stage_if.mapper  port
);
	always_comb begin
		port.word = '0;
		port.drive = 1'b1;
		if (port.replay) begin
			if (port.eight_bit && port.diff) begin
				for (int k = 0; k < PAIRS; k++) begin
					port.word[2*k] = port.samples[k];
					port.word[2*k+1] = ~port.samples[k];
				end
			end else if (port.eight_bit) begin
				// Odd bits unused in plain 8-bit mapping
				for (int k = 0; k < PAIRS; k++) begin
					port.word[2*k] = port.samples[k];
				end
			end else begin
				port.word = port.samples;
			end
		end else begin
			case (port.stop)
				diff_out_pkg::stop_low: begin
					port.word = '0;
					if (port.diff && port.modern) begin
						for (int k = 0; k < PAIRS; k++) begin
							port.word[2*k+1] = 1'b1;
						end
					end
				end
				diff_out_pkg::stop_high: begin
					port.word = '1;
					if (port.diff && port.modern) begin
						for (int k = 0; k < PAIRS; k++) begin
							port.word[2*k+1] = 1'b0;
						end
					end
				end
				default: begin
					port.drive = 1'b0;
				end
			endcase
		end
	end
endmodule : pair_mapper

// ---- logic/diff_out_top.sv ----
// Output stage of a two-module pattern generator with AXI4-Lite registers.
// Assumes replay_active and the sample stream come from logic on the same clock.
`timescale 1ns/1ps
`include "diff_out_params.svh"
module diff_out_top #(
	parameter bit MODERN_REV = 1'b1,
	parameter int MODULES    = 2,
	parameter int PAIRS      = 8
) (
	input  wire logic         clock,
	input  wire logic         sys_rst,
	// AXI4-Lite slave
	input  wire logic [19:0]  s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [19:0]  s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	// Sample stream from the replay engine
	input  wire logic         replay_active,
	input  wire logic         sample_valid,
	input  wire logic [31:0]  sample_data,
	// Output pins, one nibble per level pair
	output logic [31:0]       pattern_out,
	output logic [31:0]       pattern_oe
);
	// ********************************************************************
	// Configuration registers
	// ********************************************************************
	logic                       differential_select;
	logic                       eight_bit_mode;
	logic [31:0]                output_enable_mask;
	diff_out_pkg::stop_state_e  post_replay_state_module0;
	diff_out_pkg::stop_state_e  post_replay_state_module1;

	// ********************************************************************
	// AXI write channel
	// ********************************************************************
	logic         aw_held;
	logic [19:0]  aw_addr;
	logic         w_held;
	logic [31:0]  w_data;
	logic [3:0]   w_strb;
	logic         do_write;
	logic         write_hit;
	logic [31:0]  wr_value;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			aw_held <= 1'b0;
			aw_addr <= 20'h00000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// Ready only while the slot is empty and no response is pending
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready)
				&& !do_write;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_held && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready)
				&& !do_write;
		end
	end

	assign do_write = aw_held && w_held && !s_axi_bvalid;

	// ********************************************************************
	// Write address decode
	// ********************************************************************
	logic  hit_stop0;
	logic  hit_stop1;
	logic  hit_diff;
	logic  hit_mode;
	logic  hit_mask;

	always_comb begin
		hit_stop0 = aw_addr == `ADDR_STOP0;
		hit_stop1 = aw_addr == `ADDR_STOP1;
		hit_diff = aw_addr == `ADDR_DIFF;
		hit_mode = aw_addr == `ADDR_MODE;
		hit_mask = aw_addr == `ADDR_MASK;
	end

	always_comb begin
		write_hit = 1'b0;
		case (aw_addr)
			`ADDR_STOP0,
			`ADDR_STOP1,
			`ADDR_DIFF,
			`ADDR_MODE,
			`ADDR_MASK: write_hit = 1'b1;
			default: write_hit = 1'b0;
		endcase
	end

	// Lanes not strobed read as zero; one-bit fields also need lane 0
	always_comb begin
		wr_value = 32'h00000000;
		for (int b = 0; b < 4; b++) begin
			wr_value[8*b +: 8] = w_strb[b] ? w_data[8*b +: 8] : 8'h00;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= write_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ********************************************************************
	// Register updates
	// ********************************************************************
	logic  low_lane;

	assign low_lane = w_strb[0];

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			eight_bit_mode <= `RST_MODE;
		end else if (do_write && hit_mode && low_lane) begin
			eight_bit_mode <= wr_value[`MODE_EIGHT_BIT];
		end
	end

	// Leaving 8-bit mode also drops differential mapping
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			differential_select <= `RST_DIFF;
		end else if (do_write && hit_diff && low_lane) begin
			if (!wr_value[0]) begin
				differential_select <= 1'b0;
			end else if (eight_bit_mode) begin
				differential_select <= 1'b1;
			end
		end else if (do_write && hit_mode && low_lane && !wr_value[`MODE_EIGHT_BIT]) begin
			differential_select <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			output_enable_mask <= `RST_MASK;
		end else if (do_write && hit_mask) begin
			for (int b = 0; b < 4; b++) begin
				if (w_strb[b]) begin
					output_enable_mask[8*b +: 8] <= w_data[8*b +: 8];
				end
			end
		end
	end

	// Code 3 is not a state and leaves the setting alone
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			post_replay_state_module0 <= diff_out_pkg::stop_tristate;
			post_replay_state_module1 <= diff_out_pkg::stop_tristate;
		end else if (do_write && low_lane && wr_value[1:0] != 2'b11) begin
			if (hit_stop0) begin
				post_replay_state_module0 <= diff_out_pkg::stop_state_e'(wr_value[1:0]);
			end
			if (hit_stop1) begin
				post_replay_state_module1 <= diff_out_pkg::stop_state_e'(wr_value[1:0]);
			end
		end
	end

	// ********************************************************************
	// AXI read channel
	// ********************************************************************
	logic [31:0]  rd_value;
	logic         read_hit;

	always_comb begin
		rd_value = 32'h00000000;
		read_hit = 1'b1;
		case (s_axi_araddr)
			`ADDR_STOP0: rd_value = {30'h00000000, post_replay_state_module0};
			`ADDR_STOP1: rd_value = {30'h00000000, post_replay_state_module1};
			`ADDR_DIFF: rd_value = {31'h00000000, differential_select};
			`ADDR_MODE: rd_value = {31'h00000000, eight_bit_mode};
			`ADDR_MASK: rd_value = output_enable_mask;
			`ADDR_STATUS: begin
				rd_value[`STATUS_REPLAY] = replay_active;
				rd_value[`STATUS_DIFF] = differential_select && eight_bit_mode;
				rd_value[`STATUS_MODERN] = MODERN_REV;
			end
			default: read_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_value;
			s_axi_rresp <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ********************************************************************
	// Per-module mapping
	// ********************************************************************
	stage_if  lane [MODULES] ();
	logic     update;

	// Replay holds the last word between samples; idle shows the stop state
	assign update = !replay_active || sample_valid;

	generate
		for (genvar m = 0; m < MODULES; m++) begin : g_module
			assign lane[m].eight_bit = eight_bit_mode;
			assign lane[m].diff = differential_select && eight_bit_mode;
			// Older boards cannot complement odd bits after replay
			assign lane[m].modern = MODERN_REV;
			assign lane[m].replay = replay_active;
			assign lane[m].stop = (m == 0) ? post_replay_state_module0
				: post_replay_state_module1;
			assign lane[m].samples = eight_bit_mode
				? {8'h00, sample_data[8*m +: 8]}
				: sample_data[16*m +: 16];

			pair_mapper #(
				.PAIRS (PAIRS)
			) u_mapper (
				.port (lane[m])
			);

			// Whole word lands in one flop stage so pairs switch together
			always_ff @(posedge clock or posedge sys_rst) begin
				if (sys_rst) begin
					pattern_out[16*m +: 16] <= 16'h0000;
				end else if (update) begin
					pattern_out[16*m +: 16] <= lane[m].word;
				end
			end

			// Each nibble feeds one level-pair buffer downstream
			always_ff @(posedge clock or posedge sys_rst) begin
				if (sys_rst) begin
					pattern_oe[16*m +: 16] <= 16'h0000;
				end else if (update) begin
					pattern_oe[16*m +: 16] <= lane[m].drive
						? output_enable_mask[16*m +: 16] : 16'h0000;
				end
			end
		end
	endgenerate
endmodule : diff_out_top

// ---- tb/diff_out_top_asserts.sv ----
// Concurrent checks on the output stage top, bound to its ports.
// Assumes one write at a time and the register map of the shared header.
`timescale 1ns/1ps
`include "diff_out_params.svh"
module diff_out_top_asserts #(
	parameter bit MODERN_REV = 1'b1
) (
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire logic [19:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        replay_active,
	input wire logic        sample_valid,
	input wire logic [31:0] sample_data,
	input wire logic [31:0] pattern_out,
	input wire logic [31:0] pattern_oe
);
	// ****************************************
	// Register shadow
	// ****************************************
	logic [19:0] wa;
	logic [31:0] wd;
	logic [31:0] msk;
	logic        m8;
	logic        dif;
	logic [1:0]  st0;
	logic [1:0]  st1;
	logic        go;
	logic        idle;
	// Shadow lags the design by one edge, so cycles with a response standing are skipped
	assign go = replay_active && sample_valid && !s_axi_bvalid;
	assign idle = !replay_active && !s_axi_bvalid;

	always_ff @(posedge clock) begin
		if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			msk <= 32'h00000000;
			m8  <= 1'b0;
			dif <= 1'b0;
			st0 <= 2'h0;
			st1 <= 2'h0;
		end else if (s_axi_bvalid && s_axi_bresp == `RESP_OKAY) begin
			if (wa == `ADDR_MODE) m8 <= wd[0];
			if (wa == `ADDR_MODE && !wd[0]) dif <= 1'b0;
			if (wa == `ADDR_DIFF && (m8 || !wd[0])) dif <= wd[0];
			if (wa == `ADDR_MASK) msk <= wd;
			if (wa == `ADDR_STOP0 && wd[1:0] != 2'h3) st0 <= wd[1:0];
			if (wa == `ADDR_STOP1 && wd[1:0] != 2'h3) st1 <= wd[1:0];
		end
	end

	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_latency: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_pair_invert: assert property (
		go && dif |=> ((pattern_out ^ (pattern_out >> 1)) & 32'h55555555) == 32'h55555555)
		else $error("pair not complementary");
	a_sample_map: assert property (
		go && dif |=> pattern_out[0] == $past(sample_data[0])
		&& pattern_out[30] == $past(sample_data[15]))
		else $error("sample bit on wrong pin");
	a_single_odd: assert property (
		go && m8 && !dif |=> (pattern_out & 32'haaaaaaaa) == 32'h00000000)
		else $error("odd pin active in single-ended");
	a_replay_oe: assert property (go |=> pattern_oe == msk)
		else $error("enable differs from mask");
	a_stop_float: assert property (
		idle && st0 == 2'h0 |=> pattern_oe[15:0] == 16'h0000)
		else $error("module not floated");
	a_stop_low: assert property (
		idle && st0 == 2'h1 |=> pattern_oe[15:0] == msk[15:0]
		&& ((pattern_out[15:0] ^ ((dif && MODERN_REV) ? 16'haaaa : 16'h0000))
		& msk[15:0]) == 16'h0000)
		else $error("low stop level wrong");
	a_stop_high: assert property (
		idle && st1 == 2'h2 |=> ((pattern_out[31:16]
		^ ((dif && MODERN_REV) ? 16'h5555 : 16'hffff)) & msk[31:16]) == 16'h0000)
		else $error("high stop level wrong");
endmodule : diff_out_top_asserts

bind diff_out_top diff_out_top_asserts #(.MODERN_REV(MODERN_REV)) diff_out_top_asserts_i (
	.clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .replay_active(replay_active), .sample_valid(sample_valid),
	.sample_data(sample_data), .pattern_out(pattern_out), .pattern_oe(pattern_oe)
);

// ---- tb/pattern_receiver.sv ----
// Far-end receiver of the pattern pins.
// Assumes no pull resistors on the lines.
`timescale 1ns/1ps
module pattern_receiver (
	input  wire logic        clock,
	input  wire logic [31:0] pattern_out,
	input  wire logic [31:0] pattern_oe,
	output logic [31:0]      line
);
	logic [31:0] last = 32'h00000000;
	// A floated line drifts from its last level instead of keeping a stale copy
	assign line = (pattern_out & pattern_oe) | (~last & ~pattern_oe);
	always @(posedge clock) last <= line;
endmodule : pattern_receiver

// ---- tb/differential_output_stop_state_test.sv ----
// Self-checking bench: registers over AXI4-Lite, sample mapping and stop states.
// Assumes the design at its default revision and the receiver model on the pins.
`timescale 1ns/1ps
`include "diff_out_params.svh"
module differential_output_stop_state_test;
	logic        clock = 1'b0, sys_rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0;
	logic        arv = 1'b0, rr = 1'b0, act = 1'b0, sv = 1'b0, mark = 1'b0, due = 1'b0;
	logic        awr, wr, bv, arr, rv, dif, m8;
	logic [1:0]  bresp, rresp, st0, st1;
	logic [19:0] aw = 20'h00000, ar = 20'h00000;
	logic [31:0] wd = 32'h00000000, sd = 32'h00000000, rd, po, oe, line, msk;
	logic [31:0] rnd = 32'h7b198d24;
	logic [63:0] bq[$], rq[$], pq[$], lastp;
	int          err_count = 0, num_checks = 0;

	diff_out_top diff_out_top_i (
		.clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .replay_active(act),
		.sample_valid(sv), .sample_data(sd), .pattern_out(po), .pattern_oe(oe)
	);
	pattern_receiver pattern_receiver_i (
		.clock(clock), .pattern_out(po), .pattern_oe(oe), .line(line)
	);

	initial forever #5 clock = ~clock;

	// ****************************************
	// Checking and closing
	// ****************************************
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		err_count += pq.size() + bq.size() + rq.size();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	function automatic logic [63:0] model(input logic [31:0] s, input logic a);
		logic [31:0] o;
		logic [31:0] e;
		logic [1:0]  c;
		for (int i = 0; i < 32; i++) begin
			c = (i < 16) ? st0 : st1;
			o[i] = a ? (m8 ? (s[i / 2] && !(i % 2 && !dif)) ^ (dif && i % 2) : s[i])
				: (c == 2'h2) ^ (dif && i % 2);
			e[i] = msk[i] && (a || c != 2'h0);
		end
		return {o & e, e};
	endfunction : model

	always @(posedge clock) begin
		due <= mark;
		if (due && pq.size() > 0) check({line & oe, oe}, pq.pop_front());
		if (bv && br && bq.size() > 0) check({62'h0, bresp}, bq.pop_front());
		if (rv && rr && rq.size() > 0) check({30'h0, rresp, rd}, rq.pop_front());
	end

	// ****************************************
	// Drivers
	// ****************************************
	task automatic wreg(input logic [19:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		@(posedge clock);
		mark <= 1'b0;
		bq.push_back({62'h0, r});
		aw <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		for (n = 0; n < 50 && !bv; n++) begin
			@(posedge clock);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end
		br <= 1'b0;
		if (n == 50) err_count++;
		if (n == 50) finish_test();
	endtask : wreg

	task automatic rreg(input logic [19:0] a, input logic [33:0] e);
		int n;
		@(posedge clock);
		mark <= 1'b0;
		rq.push_back({30'h0, e});
		ar <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		for (n = 0; n < 50 && !rv; n++) begin
			@(posedge clock);
			if (arr) arv <= 1'b0;
		end
		rr <= 1'b0;
		if (n == 50) err_count++;
		if (n == 50) finish_test();
	endtask : rreg

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	task automatic pin(input logic a, input logic v);
		@(posedge clock);
		rnd = lfsr(rnd);
		act <= a;
		sv <= v;
		sd <= rnd;
		mark <= 1'b1;
		// Replay without a valid sample must hold the pins
		lastp = (a && !v) ? lastp : model(rnd, a);
		pq.push_back(lastp);
	endtask : pin

	initial begin
		{dif, m8, st0, st1, msk} = '0;
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		rreg(`ADDR_DIFF, {`RESP_OKAY, 32'h0});
		rreg(20'h00010, {`RESP_SLVERR, 32'h0});
		wreg(20'h00010, 32'h1, `RESP_SLVERR);
		wreg(`ADDR_DIFF, 32'h1, `RESP_OKAY);
		rreg(`ADDR_DIFF, {`RESP_OKAY, 32'h0});
		m8 = 1'b1;
		wreg(`ADDR_MODE, 32'h1, `RESP_OKAY);
		msk = 32'hff3fffff;
		wreg(`ADDR_MASK, msk, `RESP_OKAY);
		rreg(`ADDR_MASK, {`RESP_OKAY, msk});
		dif = 1'b1;
		wreg(`ADDR_DIFF, 32'h1, `RESP_OKAY);
		rreg(`ADDR_DIFF, {`RESP_OKAY, 32'h1});
		rreg(`ADDR_STATUS, {`RESP_OKAY, 32'h6});
		repeat (16) pin(1'b1, 1'b1);
		repeat (2) pin(1'b1, 1'b0);
		for (int c = 0; c < 3; c++) begin
			st0 = 2'(c);
			st1 = 2'(2 - c);
			wreg(`ADDR_STOP0, 32'(c), `RESP_OKAY);
			wreg(`ADDR_STOP1, 32'(2 - c), `RESP_OKAY);
			repeat (2) pin(1'b0, 1'b0);
			pin(1'b1, 1'b1);
		end
		wreg(`ADDR_STOP0, 32'h3, `RESP_OKAY);
		rreg(`ADDR_STOP0, {`RESP_OKAY, 32'h2});
		dif = 1'b0;
		wreg(`ADDR_DIFF, 32'h0, `RESP_OKAY);
		repeat (8) pin(1'b1, 1'b1);
		repeat (2) pin(1'b0, 1'b0);
		wreg(`ADDR_DIFF, 32'h1, `RESP_OKAY);
		m8 = 1'b0;
		wreg(`ADDR_MODE, 32'h0, `RESP_OKAY);
		repeat (4) pin(1'b1, 1'b1);
		rreg(`ADDR_DIFF, {`RESP_OKAY, 32'h0});
		repeat (2) @(posedge clock);
		finish_test();
	end
endmodule : differential_output_stop_state_test
